// [slu_line_unit.sv]
// Serial handshake line unit: register port, bit-serial transmit and receive
`timescale 1ns/1ns
module slu_line_unit #(
   parameter int NOT_READY_DELAY = slu_pkg::NOT_READY_CYCLES
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   // Controller register port
   input  wire logic                       regWrite,
   input  wire logic                       regRead,
   input  wire logic [slu_pkg::REG_AW-1:0] regAddr,
   input  wire logic [slu_pkg::REG_DW-1:0] regWrData,
   output logic      [slu_pkg::REG_DW-1:0] regRdData,
   // Transmit line
   input  wire logic                       remoteWantsBit,
   output logic                            bitStrobe,
   output logic                            txBit,
   output logic                            finalBit,
   // Receive line
   input  wire logic                       remoteBitStrobe,
   input  wire logic                       remoteBit,
   input  wire logic                       remoteFinalBit,
   output logic                            readyForBit,
   // Online relays
   input  wire logic                       remoteRelay,
   output logic                            hostRelay
);
   import slu_pkg::*;

   typedef struct packed {
      // Transmit side
      slu_tx_e         txState;
      logic [7:0]      txLow;
      logic [15:0]     txShift;
      logic [4:0]      txCnt;
      logic            txEmpty;
      logic            enableFinalBit;
      logic            finalArmed;
      logic            lineErrorClear;
      logic            transmitClear;
      logic            strobe;
      logic            dataBit;
      logic            finalOut;
      // Receive side
      slu_rx_e         rxState;
      logic [15:0]     rxWord;
      logic [4:0]      rxCnt;
      logic            hostReady;
      logic            receiveClear;
      logic            ready;
      logic            dataAvail;
      logic            endPending;
      logic            messageEndSeen;
      // Line status
      logic            notReady;
      logic [NR_CNT_W-1:0] nrCnt;
      logic            lineError;
      logic [7:0]      rdData;
   } slu_state_s;

   slu_state_s state_q;
   slu_state_s state_d;

   logic [4:0] syncIn;
   logic       wantsSync;
   logic       strobeSync;
   logic       bitSync;
   logic       finalSync;
   logic       relaySync;

   localparam logic [NR_CNT_W-1:0] NR_LAST = NR_CNT_W'(NOT_READY_DELAY - 1);

   // Every incoming line crosses two flops before use
   slu_sync #(
      .WIDTH (5)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .asyncIn ({remoteWantsBit, remoteBitStrobe, remoteBit, remoteFinalBit, remoteRelay}),
      .syncOut (syncIn)
   );

   assign wantsSync  = syncIn[4];
   assign strobeSync = syncIn[3];
   assign bitSync    = syncIn[2];
   assign finalSync  = syncIn[1];
   assign relaySync  = syncIn[0];

   // Next-state logic for the whole unit
   always_comb begin
      logic wrTxHigh;
      logic wrTxCtrl;
      logic wrRxCtrl;
      logic wrRxReq;
      wrTxHigh = regWrite && (regAddr == REG_TX_HIGH);
      wrTxCtrl = regWrite && (regAddr == REG_TX_CTRL);
      wrRxCtrl = regWrite && (regAddr == REG_RX_CTRL);
      wrRxReq  = regWrite && (regAddr == REG_RX_STAT);
      state_d  = state_q;

      // Low transmit byte waits for the high byte
      if (regWrite && (regAddr == REG_TX_LOW)) begin
         state_d.txLow = regWrData;
      end

      // Transmit control; clear-on-zero needs the earlier one
      if (wrTxCtrl) begin
         state_d.enableFinalBit = regWrData[BIT_ENABLE_FINAL];
         state_d.lineErrorClear = regWrData[BIT_ERROR_CLEAR];
         state_d.transmitClear  = regWrData[BIT_TX_CLEAR];
         if (state_q.lineErrorClear && !regWrData[BIT_ERROR_CLEAR] && !state_q.notReady) begin
            state_d.lineError = 1'b0;
         end
      end

      // Transmit handshake
      if (state_q.transmitClear) begin
         // Held in reset while the clear bit stands
         state_d.txState  = TX_IDLE;
         state_d.txEmpty  = 1'b1;
         state_d.txCnt    = '0;
         state_d.strobe   = 1'b0;
         state_d.finalOut = 1'b0;
      end else if (wrTxHigh) begin
         // Loading the high byte starts the word
         state_d.txShift        = {regWrData, state_q.txLow};
         state_d.dataBit        = regWrData[7];
         state_d.txEmpty        = 1'b0;
         state_d.txCnt          = '0;
         state_d.txState        = TX_WAIT;
         state_d.finalArmed     = state_q.enableFinalBit;
         state_d.enableFinalBit = 1'b0;
         state_d.strobe         = 1'b0;
         state_d.finalOut       = 1'b0;
      end else begin
         unique case (state_q.txState)
            TX_IDLE: begin
               state_d.strobe = 1'b0;
            end
            TX_WAIT: begin
               // Strobe only while the remote asks; data already stable
               if (wantsSync) begin
                  state_d.strobe   = 1'b1;
                  state_d.finalOut = state_q.finalArmed && (state_q.txCnt == LAST_IDX);
                  state_d.txState  = TX_HOLD;
               end
            end
            TX_HOLD: begin
               // Remote dropped ready: release strobe, move to next bit
               if (!wantsSync) begin
                  state_d.strobe   = 1'b0;
                  state_d.finalOut = 1'b0;
                  state_d.txShift  = {state_q.txShift[14:0], 1'b0};
                  state_d.dataBit  = state_q.txShift[14];
                  state_d.txCnt    = state_q.txCnt + 5'h01;
                  if (state_q.txCnt == LAST_IDX) begin
                     state_d.txEmpty    = 1'b1;
                     state_d.finalArmed = 1'b0;
                     state_d.txState    = TX_IDLE;
                  end else begin
                     state_d.txState = TX_WAIT;
                  end
               end
            end
         endcase
      end

      // Receive control; setting receive clear drops host-ready
      if (wrRxCtrl) begin
         state_d.receiveClear = regWrData[BIT_RX_CLEAR];
         state_d.hostReady    = regWrData[BIT_HOST_READY] && !regWrData[BIT_RX_CLEAR];
      end

      // High byte read consumes the word; completion below wins
      if (regRead && (regAddr == REG_RX_HIGH)) begin
         state_d.dataAvail      = 1'b0;
         state_d.messageEndSeen = 1'b0;
      end

      // Receive handshake
      if (state_q.receiveClear) begin
         // Frozen in reset while the clear bit stands
         state_d.rxState        = RX_IDLE;
         state_d.ready          = 1'b0;
         state_d.rxCnt          = '0;
         state_d.rxWord[15:8]   = 8'h00;
         state_d.dataAvail      = 1'b0;
         state_d.endPending     = 1'b0;
         state_d.messageEndSeen = 1'b0;
      end else begin
         // Final-bit line caught anywhere in the word
         if (state_q.rxState != RX_IDLE && finalSync) begin
            state_d.endPending = 1'b1;
         end
         unique case (state_q.rxState)
            RX_IDLE: begin
               // One request per word; nothing raises ready otherwise
               if (wrRxReq && regWrData[BIT_GET_WORD]) begin
                  state_d.ready   = 1'b1;
                  state_d.rxCnt   = '0;
                  state_d.rxState = RX_REQ;
               end
            end
            RX_REQ: begin
               // Strobe seen: take the bit, withdraw ready
               if (strobeSync) begin
                  state_d.rxWord  = {state_q.rxWord[14:0], bitSync};
                  state_d.ready   = 1'b0;
                  state_d.rxState = RX_ACK;
               end
            end
            RX_ACK: begin
               // Strobe gone: ask again, or finish after sixteen
               if (!strobeSync) begin
                  state_d.rxCnt = state_q.rxCnt + 5'h01;
                  if (state_q.rxCnt == LAST_IDX) begin
                     state_d.dataAvail      = 1'b1;
                     state_d.messageEndSeen = state_q.endPending || finalSync;
                     state_d.endPending     = 1'b0;
                     state_d.rxState        = RX_IDLE;
                  end else begin
                     state_d.ready   = 1'b1;
                     state_d.rxState = RX_REQ;
                  end
               end
            end
         endcase
      end

      // Remote relay: drop at once, recover only after the settle time
      if (!relaySync) begin
         state_d.notReady = 1'b1;
         state_d.nrCnt    = '0;
      end else if (state_q.notReady) begin
         if (state_q.nrCnt >= NR_LAST) begin
            state_d.notReady = 1'b0;
            state_d.nrCnt    = '0;
         end else begin
            state_d.nrCnt = state_q.nrCnt + NR_CNT_W'(1);
         end
      end

      // Not-ready holds the error; set wins over a clear
      if (state_q.notReady) begin
         state_d.lineError = 1'b1;
      end

      // Read data, registered; write-only data reads as zero
      state_d.rdData = 8'h00;
      if (regRead) begin
         unique case (regAddr)
            REG_TX_CTRL: begin
               state_d.rdData[BIT_ENABLE_FINAL] = state_q.enableFinalBit;
               state_d.rdData[BIT_ERROR_CLEAR]  = state_q.lineErrorClear;
               state_d.rdData[BIT_TX_CLEAR]     = state_q.transmitClear;
            end
            REG_TX_STAT: begin
               state_d.rdData[BIT_NOT_READY]    = state_q.notReady;
               state_d.rdData[BIT_WANTS_BIT]    = wantsSync;
               state_d.rdData[BIT_BUFFER_EMPTY] = state_q.txEmpty;
            end
            REG_RX_LOW: begin
               state_d.rdData = state_q.rxWord[7:0];
            end
            REG_RX_HIGH: begin
               state_d.rdData = state_q.rxWord[15:8];
            end
            REG_RX_CTRL: begin
               state_d.rdData[BIT_HOST_READY] = state_q.hostReady;
               state_d.rdData[BIT_RX_CLEAR]   = state_q.receiveClear;
            end
            REG_RX_STAT: begin
               state_d.rdData[BIT_LINE_ERROR]  = state_q.lineError;
               state_d.rdData[BIT_MESSAGE_END] = state_q.messageEndSeen;
               state_d.rdData[BIT_DATA_AVAIL]  = state_q.dataAvail;
            end
            default: begin
               state_d.rdData = 8'h00;
            end
         endcase
      end
   end

   // State register; relay starts released so not-ready begins set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q          <= '0;
         state_q.txState  <= TX_IDLE;
         state_q.rxState  <= RX_IDLE;
         state_q.txEmpty  <= RST_EMPTY;
         state_q.notReady <= RST_NOT_READY;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs straight from flops
   assign regRdData   = state_q.rdData;
   assign bitStrobe   = state_q.strobe;
   assign txBit       = state_q.dataBit;
   assign finalBit    = state_q.finalOut;
   assign readyForBit = state_q.ready;
   assign hostRelay   = state_q.hostReady;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_load_clears_empty: assert property (
      regWrite && regAddr == REG_TX_HIGH && !state_q.transmitClear |=> !state_q.txEmpty && state_q.txState == TX_WAIT)
      else $error("high byte load did not start transfer");

   chk_strobe_needs_ready: assert property (
      $rose(bitStrobe) |-> $past(wantsSync) && state_q.txState == TX_HOLD)
      else $error("strobe raised without remote ready");

   chk_tx_clear_empty: assert property (
      state_q.transmitClear |=> state_q.txEmpty && !bitStrobe)
      else $error("transmit clear did not reset transmitter");

   chk_no_ready_after_word: assert property (
      $rose(state_q.dataAvail) |-> !readyForBit ##1 !readyForBit)
      else $error("ready raised after sixteenth bit");

   chk_error_follows_nr: assert property (
      state_q.notReady |=> state_q.lineError [*2])
      else $error("line error not held by not-ready");

   chk_high_read_clears: assert property (
      regRead && regAddr == REG_RX_HIGH && state_q.rxState != RX_ACK |=> !state_q.dataAvail)
      else $error("high byte read left data available");

   chk_low_read_keeps: assert property (
      regRead && regAddr == REG_RX_LOW && state_q.dataAvail && !state_q.receiveClear |=> state_q.dataAvail)
      else $error("low byte read disturbed data available");

   chk_rx_clear_freeze: assert property (
      state_q.receiveClear |=> !readyForBit && state_q.rxWord[15:8] == 8'h00)
      else $error("receive logic not frozen by clear");

   chk_host_ready_drop: assert property (
      regWrite && regAddr == REG_RX_CTRL && regWrData[BIT_RX_CLEAR] |=> !hostRelay)
      else $error("receive clear left host ready set");

   chk_end_with_avail: assert property (
      $rose(state_q.messageEndSeen) |-> $rose(state_q.dataAvail))
      else $error("message end shown apart from data available");

   chk_relay_drop: assert property (
      !relaySync |=> state_q.notReady)
      else $error("relay release missed");

endmodule // slu_line_unit

// [slu_pkg.sv]
// Constants and types shared by the serial handshake line unit
package slu_pkg;

   // Register port geometry
   localparam int REG_AW = 3;
   localparam int REG_DW = 8;

   // Register indices, eight addresses shared by five write and six read registers
   localparam logic [2:0] REG_TX_LOW   = 3'h0;
   localparam logic [2:0] REG_TX_HIGH  = 3'h1;
   localparam logic [2:0] REG_TX_CTRL  = 3'h2;
   localparam logic [2:0] REG_TX_STAT  = 3'h3;
   localparam logic [2:0] REG_RX_LOW   = 3'h4;
   localparam logic [2:0] REG_RX_HIGH  = 3'h5;
   localparam logic [2:0] REG_RX_CTRL  = 3'h6;
   localparam logic [2:0] REG_RX_STAT  = 3'h7;

   // Field positions, transmit control and status
   localparam int BIT_ENABLE_FINAL  = 4;
   localparam int BIT_ERROR_CLEAR   = 1;
   localparam int BIT_TX_CLEAR      = 0;
   localparam int BIT_NOT_READY     = 4;
   localparam int BIT_WANTS_BIT     = 1;
   localparam int BIT_BUFFER_EMPTY  = 0;

   // Field positions, receive control, request and status
   localparam int BIT_HOST_READY    = 1;
   localparam int BIT_RX_CLEAR      = 0;
   localparam int BIT_GET_WORD      = 0;
   localparam int BIT_LINE_ERROR    = 4;
   localparam int BIT_MESSAGE_END   = 1;
   localparam int BIT_DATA_AVAIL    = 0;

   // Word geometry
   localparam int         WORD_BITS = 16;
   localparam logic [4:0] LAST_IDX  = 5'h0f;

   // Remote relay settle time
   localparam int CLK_HZ           = 100_000_000;
   localparam int NOT_READY_MS     = 500;
   localparam int NOT_READY_CYCLES = NOT_READY_MS * (CLK_HZ / 1000);
   localparam int NR_CNT_W         = 26;

   // Reset values
   localparam logic RST_EMPTY      = 1'b1;
   localparam logic RST_NOT_READY  = 1'b1;

   // Transmit handshake states
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_WAIT = 3'b010,
      TX_HOLD = 3'b100
   } slu_tx_e;

   // Receive handshake states
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_REQ  = 3'b010,
      RX_ACK  = 3'b100
   } slu_rx_e;

endpackage

// [slu_sync.sv]
// Two flip-flop synchroniser for asynchronous line inputs
`timescale 1ns/1ns
module slu_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Asynchronous inputs and their synchronised copies
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   import slu_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } slu_sync_s;

   slu_sync_s state_q;
   slu_sync_s state_d;

   // First stage feeds only the second stage
   always_comb begin
      state_d        = state_q;
      state_d.meta   = asyncIn;
      state_d.stable = state_q.meta;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign syncOut = state_q.stable;

endmodule // slu_sync

// [slu_remote_model.sv]
// Behavioural model of the remote processor on the handshake lines
`timescale 1ns/1ns
module slu_remote_model (
   // Clock
   input  wire logic        clk,
   // Transmit line, unit to remote
   input  wire logic        bitStrobe,
   input  wire logic        txBit,
   input  wire logic        finalBit,
   output logic             remoteWantsBit,
   // Receive line, remote to unit
   input  wire logic        readyForBit,
   output logic             remoteBitStrobe,
   output logic             remoteBit,
   output logic             remoteFinalBit,
   // Online relay
   output logic             remoteRelay,
   // Test controls and results
   input  wire logic        acceptEn,
   input  wire logic [3:0]  slowCycles,
   input  wire logic        relayOn,
   input  wire logic [15:0] sendWord,
   input  wire logic [3:0]  sendFinalIdx,
   output logic      [15:0] gotWord,
   output logic      [15:0] finalMask,
   output logic      [7:0]  gotCount
);
   logic [3:0] rxIdx;

   // Relay follows the bench's online order
   assign remoteRelay = relayOn;

   // Take bits: request, sample on strobe, drop, wait for strobe low
   initial begin
      remoteWantsBit = 1'b0;
      gotWord = 16'h0000;
      finalMask = 16'h0000;
      gotCount = 8'h00;
      forever begin
         @(posedge clk);
         #1;
         if (acceptEn && !bitStrobe) begin
            repeat (slowCycles) @(posedge clk);
            #1;
            remoteWantsBit = 1'b1;
            while (acceptEn && !bitStrobe) begin
               @(posedge clk);
               #1;
            end
            if (bitStrobe) begin
               gotWord = {gotWord[14:0], txBit};
               finalMask = {finalMask[14:0], finalBit};
               gotCount = gotCount + 8'h01;
            end
            // Ready falls once the strobe is seen or acceptEn drops
            remoteWantsBit = 1'b0;
            while (bitStrobe) begin
               @(posedge clk);
               #1;
            end
         end
      end
   end

   // Send bits: data a cycle ahead of strobe, strobe held until ready drops
   initial begin
      remoteBitStrobe = 1'b0;
      remoteBit = 1'b0;
      remoteFinalBit = 1'b0;
      rxIdx = 4'h0;
      forever begin
         @(posedge clk);
         #1;
         if (readyForBit && !remoteBitStrobe) begin
            repeat (slowCycles) @(posedge clk);
            #1;
            remoteBit = sendWord[4'hf - rxIdx]; // MSB first
            remoteFinalBit = (rxIdx == sendFinalIdx);
            @(posedge clk);
            #1;
            remoteBitStrobe = 1'b1;
            while (readyForBit) begin
               @(posedge clk);
               #1;
            end
            remoteBitStrobe = 1'b0;
            remoteBit = ~remoteBit; // Released line never keeps the old bit
            remoteFinalBit = 1'b0;
            rxIdx = rxIdx + 4'h1;
         end
      end
   end
endmodule // slu_remote_model

// [slu_line_unit_tb_top.sv]
// Self-checking bench for the serial handshake line unit
`timescale 1ns/1ns
module slu_line_unit_tb_top;
   import slu_pkg::*;
   // Short relay settle time keeps the run brief
   localparam int NR_DELAY = 40;
   logic                clk, sys_rst, regWrite, regRead;
   logic [REG_AW-1:0]   regAddr;
   logic [REG_DW-1:0]   regWrData, regRdData, rd;
   logic                remoteWantsBit, bitStrobe, txBit, finalBit;
   logic                remoteBitStrobe, remoteBit, remoteFinalBit, readyForBit;
   logic                remoteRelay, hostRelay, acceptEn, relayOn;
   logic [3:0]          slowCycles;
   logic [15:0]         gotWord, finalMask;
   logic [7:0]          gotCount, target;
   logic [15:0]         txWords [2];
   int                  n_fail, num_checks, cycles, k, i;

   // Clock
   initial clk = 1'b0;
   always #5 clk = ~clk;

   slu_line_unit #(.NOT_READY_DELAY(NR_DELAY)) DUT (
      .clk(clk), .sys_rst(sys_rst), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .remoteWantsBit(remoteWantsBit), .bitStrobe(bitStrobe), .txBit(txBit),
      .finalBit(finalBit), .remoteBitStrobe(remoteBitStrobe), .remoteBit(remoteBit),
      .remoteFinalBit(remoteFinalBit), .readyForBit(readyForBit),
      .remoteRelay(remoteRelay), .hostRelay(hostRelay));

   slu_remote_model remote (
      .clk(clk), .bitStrobe(bitStrobe), .txBit(txBit), .finalBit(finalBit),
      .remoteWantsBit(remoteWantsBit), .readyForBit(readyForBit),
      .remoteBitStrobe(remoteBitStrobe), .remoteBit(remoteBit),
      .remoteFinalBit(remoteFinalBit), .remoteRelay(remoteRelay), .acceptEn(acceptEn),
      .slowCycles(slowCycles), .relayOn(relayOn), .sendWord(16'h3c5a),
      .sendFinalIdx(4'h9), .gotWord(gotWord), .finalMask(finalMask), .gotCount(gotCount));

   // Register port cycles
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      #1; // Let outputs launched by this write settle before callers look
   endtask

   task automatic rdReg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdData; // Read data stands for one cycle only
   endtask

   // Comparisons
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s: got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s: got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic expect8(input logic [2:0] a, input logic [7:0] exp, input string m);
      logic [7:0] d;
      rdReg(a, d);
      chk8(d, exp, m);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         $display("[ERR] %0t timeout", $time);
         conclude();
      end
   end

   initial begin
      sys_rst = 1'b1;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 3'h0;
      regWrData = 8'h00;
      acceptEn = 1'b0;
      relayOn = 1'b1;
      slowCycles = 4'h0;
      txWords[0] = 16'ha5c3;
      txWords[1] = 16'h1e81;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      // Relay still settling: not ready, error latched and held
      expect8(REG_TX_STAT, 8'h11, "txstat rst");
      expect8(REG_RX_STAT, 8'h10, "rxstat rst");
      expect8(REG_TX_LOW, 8'h00, "tx low rd");
      wr(REG_TX_CTRL, 8'h02);
      wr(REG_TX_CTRL, 8'h00);
      expect8(REG_RX_STAT, 8'h10, "err held");
      repeat (60) @(posedge clk);
      expect8(REG_TX_STAT, 8'h01, "ready");
      expect8(REG_RX_STAT, 8'h10, "err sticks");
      wr(REG_TX_CTRL, 8'h02);
      wr(REG_TX_CTRL, 8'h00);
      expect8(REG_RX_STAT, 8'h00, "err clear");
      wr(REG_TX_CTRL, 8'h12);
      expect8(REG_TX_CTRL, 8'h12, "txctl rb");
      wr(REG_TX_CTRL, 8'h00);
      wr(REG_RX_CTRL, 8'h02);
      expect8(REG_RX_CTRL, 8'h02, "rxctl rb");
      chk8({7'h0, hostRelay}, 8'h01, "host relay");
      // Wants-bit status follows the remote line both ways
      @(posedge clk);
      acceptEn <= 1'b1;
      repeat (8) @(posedge clk);
      expect8(REG_TX_STAT, 8'h03, "wants hi");
      @(posedge clk);
      acceptEn <= 1'b0;
      repeat (8) @(posedge clk);
      expect8(REG_TX_STAT, 8'h01, "wants lo");
      // Two words: first armed for final bit and prompt, second plain and slow
      for (k = 0; k < 2; k++) begin
         wr(REG_TX_CTRL, (k == 0) ? 8'h10 : 8'h00);
         wr(REG_TX_LOW, txWords[k][7:0]);
         wr(REG_TX_HIGH, txWords[k][15:8]);
         expect8(REG_TX_STAT, 8'h00, "empty clr");
         target = gotCount + 8'd16;
         @(posedge clk);
         acceptEn <= 1'b1;
         slowCycles <= (k == 0) ? 4'h0 : 4'h3;
         for (i = 0; i < 3000 && gotCount !== target; i++) @(posedge clk);
         acceptEn <= 1'b0;
         chk8(gotCount, target, "bit count");
         chk16(gotWord, txWords[k], "tx word");
         chk16(finalMask, (k == 0) ? 16'h0001 : 16'h0000, "final");
         repeat (6) @(posedge clk);
         expect8(REG_TX_STAT, 8'h01, "empty set");
         expect8(REG_TX_CTRL, 8'h00, "final self clr");
      end
      // Transmit clear drops a loaded word; high byte refused meanwhile
      wr(REG_TX_LOW, 8'ha1);
      wr(REG_TX_HIGH, 8'hb2);
      wr(REG_TX_CTRL, 8'h01);
      wr(REG_TX_HIGH, 8'h55);
      wr(REG_TX_CTRL, 8'h00);
      expect8(REG_TX_STAT, 8'h01, "tx clear");
      @(posedge clk);
      acceptEn <= 1'b1;
      repeat (30) @(posedge clk);
      acceptEn <= 1'b0;
      chk8(gotCount, target, "no bits");
      // Receive one word with final bit mid-word
      wr(REG_RX_STAT, 8'h01);
      for (i = 0; i < 100; i++) begin
         rdReg(REG_RX_STAT, rd);
         if (rd[0] === 1'b1) break;
      end
      chk8(rd, 8'h03, "avail eom");
      expect8(REG_RX_LOW, 8'h5a, "rx low");
      expect8(REG_RX_STAT, 8'h03, "avail kept");
      expect8(REG_RX_HIGH, 8'h3c, "rx high");
      expect8(REG_RX_STAT, 8'h00, "avail clr");
      repeat (10) @(posedge clk);
      chk8({7'h0, readyForBit}, 8'h00, "no ready");
      // Receive clear: relay dropped, logic frozen, high byte zeroed
      wr(REG_RX_CTRL, 8'h01);
      chk8({7'h0, hostRelay}, 8'h00, "relay off");
      wr(REG_RX_STAT, 8'h01);
      repeat (10) @(posedge clk);
      chk8({7'h0, readyForBit}, 8'h00, "frozen");
      wr(REG_RX_CTRL, 8'h00);
      expect8(REG_RX_HIGH, 8'h00, "rx high zero");
      // Remote relay drop and slow recovery
      @(posedge clk);
      relayOn <= 1'b0;
      repeat (6) @(posedge clk);
      expect8(REG_TX_STAT, 8'h11, "not ready");
      expect8(REG_RX_STAT, 8'h10, "err set");
      @(posedge clk);
      relayOn <= 1'b1;
      repeat (15) @(posedge clk);
      expect8(REG_TX_STAT, 8'h11, "settling");
      repeat (40) @(posedge clk); // Wait out the settle time before expecting ready
      expect8(REG_TX_STAT, 8'h01, "settled");
      expect8(REG_RX_STAT, 8'h10, "err kept");
      wr(REG_TX_CTRL, 8'h02);
      wr(REG_TX_CTRL, 8'h00);
      expect8(REG_RX_STAT, 8'h00, "err gone");
      conclude();
   end
endmodule // slu_line_unit_tb_top
